// [rtl/pcrsh_top.sv]
// Reference selection, holdover history and bandwidth apply logic for the third loop
//
// How it works
// - Unmasked loss alarm disqualifies its input
// - Unmasked offset alarm disqualifies its input
// - Input n: mask bits n and n+4
// - Selection outcome can force holdover entry
// - Three-bit ranks, zero none, 5-7 reserved
// - Ten-bit phase threshold split over two registers
// - History-valid status bit, holdover versus free-run
// - Fast-lock status bit shows bandwidth in use
// - History accumulation stops in holdover/free-run
// - New valid input clears and restarts history
// - Six six-bit holdover-exit bandwidth parameters
// - Bandwidths apply on update bit or full reset
// - Loop soft reset keeps applied bandwidths
// - Mode: manual, non-revertive, revertive, reserved
// - Manual select picks input 0 to 3
//
// Chosen here: the APB slave port.
module pcrsh_top #(
	parameter int unsigned HIST_LEN = pcrsh_pkg::HIST_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pcrsh_pkg::ADDR_W+1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire pcrsh_pkg::pcrsh_alarms_t ref_alarms,
	input wire logic fast_lock_engaged,
	output pcrsh_pkg::pcrsh_loop_t loop_status,
	output logic [9:0] phase_measure_threshold,
	output logic hitless_enable,
	output logic [5:0] exit_bandwidth_param [pcrsh_pkg::N_EXIT_BW]
);
	import pcrsh_pkg::*;

	logic [7:0] alarm_mask_ff;
	logic [7:0] rank01_ff;
	logic [7:0] rank23_ff;
	logic [2:0] sel_mode_ff;
	logic [2:0] manual_sel_ff;
	logic [7:0] cfg_ff [N_CFG];
	logic [5:0] applied_bw_ff [N_EXIT_BW];
	logic pready_ff;
	logic pslverr_ff;
	logic [31:0] prdata_ff;
	logic fast_ff;
	pcrsh_state_t state_ff;
	pcrsh_state_t nxt_state;
	logic [1:0] active_ff;
	logic [1:0] nxt_active;
	logic hist_valid_ff;
	logic [$clog2(HIST_LEN+1)-1:0] hist_cnt_ff;
	pcrsh_loop_t status_ff;

	logic [ADDR_W-1:0] idx;
	logic access;
	logic wr_en;
	logic hit;
	logic [7:0] rd_byte;
	logic soft_all;
	logic soft_loop;
	logic bw_apply;
	logic [2:0] rank [4];
	logic [3:0] qualified;
	logic [3:0] ranked_ok;
	logic any_ok;
	logic [1:0] best;
	logic [2:0] best_rank;
	pcrsh_mode_t mode;

	assign idx = paddr[ADDR_W+1:2];
	assign access = psel && penable && !pready_ff;
	assign wr_en = psel && penable && pready_ff && pwrite && !pslverr_ff;
	assign soft_all = wr_en && idx == IDX_SOFT_RESET && pwdata[SOFT_ALL_BIT];
	assign soft_loop = wr_en && idx == IDX_SOFT_RESET && pwdata[SOFT_LOOP_BIT];
	assign bw_apply = wr_en && idx == IDX_BW_APPLY && pwdata[BW_APPLY_BIT];
	assign mode = pcrsh_mode_t'(sel_mode_ff[1:0]);

	// Read mux and decode; unmapped indices answer with an error and zero data
	always_comb
	begin
		rd_byte = 8'h00;
		hit = 1'b1;
		case (idx)
			IDX_SOFT_RESET, IDX_BW_APPLY: rd_byte = 8'h00;
			IDX_MANUAL_SEL: rd_byte = {5'h00, manual_sel_ff};
			IDX_SEL_MODE: rd_byte = {5'h00, sel_mode_ff};
			IDX_ALARM_MASK: rd_byte = alarm_mask_ff;
			IDX_RANK01: rd_byte = rank01_ff;
			IDX_RANK23: rd_byte = rank23_ff;
			IDX_HIST_STATUS:
			begin
				rd_byte[HIST_VALID_BIT] = hist_valid_ff;
				rd_byte[FAST_ACTIVE_BIT] = fast_ff;
			end
			IDX_ACTIVE:
				rd_byte = {3'h0, state_ff == ST_LOCKED, state_ff == ST_HOLDOVER,
					state_ff == ST_FREERUN, active_ff};
			default:
			begin
				hit = 1'b0;
				for (int i = 0; i < N_CFG; i++)
				begin
					if (idx == CFG_IDX[i])
					begin
						hit = 1'b1;
						rd_byte = cfg_ff[i];
					end
				end
			end
		endcase
	end

	// One wait state: the answer comes in the second access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end
		else
		begin
			pready_ff <= access;
			pslverr_ff <= access && !hit;
			if (access && !pwrite)
				prdata_ff <= {24'h00_0000, rd_byte};
			else if (!access)
				prdata_ff <= 32'h0000_0000;
		end
	end

	// Selection registers; reserved bits are not stored
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			alarm_mask_ff <= ALARM_MASK_RST;
			rank01_ff <= RANK_RST;
			rank23_ff <= RANK_RST;
			sel_mode_ff <= SEL_MODE_RST;
			manual_sel_ff <= MANUAL_SEL_RST;
		end
		else if (wr_en)
		begin
			case (idx)
				IDX_ALARM_MASK: alarm_mask_ff <= pwdata[7:0];
				IDX_RANK01: rank01_ff <= pwdata[7:0] & 8'h77;
				IDX_RANK23: rank23_ff <= pwdata[7:0] & 8'h77;
				IDX_SEL_MODE: sel_mode_ff <= pwdata[2:0];
				IDX_MANUAL_SEL: manual_sel_ff <= pwdata[2:0];
				default: ;
			endcase
		end
	end

	// Stored configuration bytes, including threshold halves and staged exit bandwidths
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < N_CFG; i++)
				cfg_ff[i] <= CFG_RESET[i];
		end
		else if (wr_en)
		begin
			for (int i = 0; i < N_CFG; i++)
			begin
				if (idx == CFG_IDX[i])
					cfg_ff[i] <= pwdata[7:0] & CFG_MASK[i];
			end
		end
	end

	// Staged exit bandwidths reach the loop only on the apply bit or a full soft reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < N_EXIT_BW; i++)
				applied_bw_ff[i] <= 6'h00;
		end
		else if (bw_apply || soft_all)
		begin
			for (int i = 0; i < N_EXIT_BW; i++)
				applied_bw_ff[i] <= cfg_ff[CFG_EXIT_BW + i][5:0];
		end
		// A loop-only soft reset falls through and keeps the applied set
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			fast_ff <= 1'b0;
		else
			fast_ff <= fast_lock_engaged;
	end

	// Qualification: an alarm counts only while its mask bit is zero
	always_comb
	begin
		rank[0] = rank01_ff[2:0];
		rank[1] = rank01_ff[RANK_HI_LSB+:3];
		rank[2] = rank23_ff[2:0];
		rank[3] = rank23_ff[RANK_HI_LSB+:3];
		for (int n = 0; n < 4; n++)
		begin
			qualified[n] = !(ref_alarms.loss[n] && !alarm_mask_ff[n])
				&& !(ref_alarms.offset[n] && !alarm_mask_ff[n + OOF_MASK_LSB]);
			// Reserved ranks are treated like no rank so they never win
			ranked_ok[n] = qualified[n] && rank[n] != 3'h0 && rank[n] <= RANK_MAX;
		end
	end

	// Best ranked input: lowest rank number wins, lower index breaks a tie
	always_comb
	begin
		best = 2'd0;
		best_rank = 3'h7;
		any_ok = 1'b0;
		for (int n = 3; n >= 0; n--)
		begin
			if (ranked_ok[n] && rank[n] <= best_rank)
			begin
				best = 2'(n);
				best_rank = rank[n];
				any_ok = 1'b1;
			end
		end
	end

	// Selection outcome decides locking; with no usable input it enters holdover if history is valid, else free-run
	always_comb
	begin
		nxt_state = state_ff;
		nxt_active = active_ff;
		case (mode)
			MODE_MANUAL:
			begin
				if (manual_sel_ff <= 3'd3)
				begin
					nxt_active = manual_sel_ff[1:0];
					nxt_state = qualified[manual_sel_ff[1:0]] ? ST_LOCKED : ST_FREERUN;
				end
				else
					nxt_state = ST_FREERUN;
			end
			MODE_NONREVERT:
			begin
				if (state_ff == ST_LOCKED && ranked_ok[active_ff])
					nxt_state = ST_LOCKED;
				else if (any_ok)
				begin
					nxt_active = best;
					nxt_state = ST_LOCKED;
				end
				else
					nxt_state = ST_FREERUN;
			end
			MODE_REVERT:
			begin
				if (any_ok)
				begin
					nxt_active = best;
					nxt_state = ST_LOCKED;
				end
				else
					nxt_state = ST_FREERUN;
			end
			default:
				nxt_state = ST_FREERUN;
		endcase
		// Leaving lock, or a switch, uses the history if there is one
		if ((state_ff == ST_LOCKED || state_ff == ST_HOLDOVER) && hist_valid_ff
			&& (nxt_state == ST_FREERUN || (nxt_state == ST_LOCKED && nxt_active != active_ff)))
			nxt_state = (nxt_state == ST_FREERUN) ? ST_HOLDOVER : ST_LOCKED;
		if (nxt_state == ST_FREERUN && state_ff == ST_HOLDOVER && hist_valid_ff)
			nxt_state = ST_HOLDOVER;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_ff <= ST_FREERUN;
			active_ff <= 2'd0;
		end
		else if (soft_loop || soft_all)
		begin
			state_ff <= ST_FREERUN;
			active_ff <= 2'd0;
		end
		else
		begin
			state_ff <= nxt_state;
			active_ff <= nxt_active;
		end
	end

	// Status pins are a registered copy of the next state, so they track state_ff without decode glitches
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			status_ff.locked <= 1'b0;
			status_ff.holdover <= 1'b0;
			status_ff.freerun <= 1'b1;
			status_ff.input_num <= 2'd0;
		end
		else if (soft_loop || soft_all)
		begin
			status_ff.locked <= 1'b0;
			status_ff.holdover <= 1'b0;
			status_ff.freerun <= 1'b1;
			status_ff.input_num <= 2'd0;
		end
		else
		begin
			status_ff.locked <= nxt_state == ST_LOCKED;
			status_ff.holdover <= nxt_state == ST_HOLDOVER;
			status_ff.freerun <= nxt_state == ST_FREERUN;
			status_ff.input_num <= nxt_active;
		end
	end

	// History: accumulate only while locked; a fresh lock or a switch restarts it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			hist_cnt_ff <= '0;
			hist_valid_ff <= 1'b0;
		end
		else if (soft_loop || soft_all)
		begin
			hist_cnt_ff <= '0;
			hist_valid_ff <= 1'b0;
		end
		else if (nxt_state == ST_LOCKED && (state_ff != ST_LOCKED || nxt_active != active_ff))
		begin
			// The old history stays valid until now so the switch itself rides on it
			hist_cnt_ff <= '0;
			hist_valid_ff <= 1'b0;
		end
		else if (state_ff == ST_LOCKED && nxt_state == ST_LOCKED)
		begin
			if (hist_cnt_ff == ($bits(hist_cnt_ff))'(HIST_LEN))
				hist_valid_ff <= 1'b1;
			else
				hist_cnt_ff <= hist_cnt_ff + 1'b1;
		end
		// Holdover and free-run freeze the count
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign loop_status = status_ff;
	assign phase_measure_threshold = {cfg_ff[CFG_THR_HI][1:0], cfg_ff[CFG_THR_LO]};
	assign hitless_enable = sel_mode_ff[HSW_EN_BIT];
	assign exit_bandwidth_param = applied_bw_ff;
endmodule

// [rtl/pcrsh_pkg.sv]
// Package for reference selection and holdover supervision of the third loop
package pcrsh_pkg;
	localparam int unsigned ADDR_W = 12;
	// Printed offsets are register indices; byte address is four times the index
	localparam logic [ADDR_W-1:0] IDX_SOFT_RESET = 12'h0_01C;
	localparam logic [ADDR_W-1:0] IDX_BW_APPLY = 12'h0_614;
	localparam logic [ADDR_W-1:0] IDX_MANUAL_SEL = 12'h0_62A;
	localparam logic [ADDR_W-1:0] IDX_SEL_MODE = 12'h0_636;
	localparam logic [ADDR_W-1:0] IDX_ALARM_MASK = 12'h0_637;
	localparam logic [ADDR_W-1:0] IDX_RANK01 = 12'h0_638;
	localparam logic [ADDR_W-1:0] IDX_RANK23 = 12'h0_639;
	localparam logic [ADDR_W-1:0] IDX_HIST_STATUS = 12'h0_63F;
	localparam logic [ADDR_W-1:0] IDX_ACTIVE = 12'h0_6F0;
	// Stored configuration bytes: index, writable bits, reset value
	localparam int unsigned N_CFG = 19;
	localparam int unsigned CFG_HSW = 0;
	localparam int unsigned CFG_THR_LO = 1;
	localparam int unsigned CFG_THR_HI = 2;
	localparam int unsigned CFG_EXIT_BW = 13;
	localparam int unsigned N_EXIT_BW = 6;
	localparam logic [ADDR_W-1:0] CFG_IDX [N_CFG] = '{
		12'h0_63A, 12'h0_63B, 12'h0_63C, 12'h0_63D, 12'h0_63E, 12'h0_642, 12'h0_643,
		12'h0_644, 12'h0_645, 12'h0_688, 12'h0_689, 12'h0_69B, 12'h0_6A6,
		12'h0_69D, 12'h0_69E, 12'h0_69F, 12'h0_6A0, 12'h0_6A1, 12'h0_6A2};
	localparam logic [7:0] CFG_MASK [N_CFG] = '{
		8'h0F, 8'hFF, 8'h03, 8'h1F, 8'h1F, 8'hFF, 8'hFF, 8'h03, 8'h02, 8'h0F, 8'hFF, 8'hF6, 8'h0F,
		8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'h3F};
	localparam logic [7:0] CFG_RESET [N_CFG] = '{
		8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	// Field positions
	localparam int unsigned SOFT_ALL_BIT = 0;
	localparam int unsigned SOFT_LOOP_BIT = 3;
	localparam int unsigned BW_APPLY_BIT = 0;
	localparam int unsigned HIST_VALID_BIT = 1;
	localparam int unsigned FAST_ACTIVE_BIT = 2;
	localparam int unsigned OOF_MASK_LSB = 4;
	localparam int unsigned RANK_HI_LSB = 4;
	localparam int unsigned HSW_EN_BIT = 2;
	// Reset values of the selection registers, and the highest usable rank
	localparam logic [7:0] ALARM_MASK_RST = 8'h00;
	localparam logic [7:0] RANK_RST = 8'h00;
	localparam logic [2:0] SEL_MODE_RST = 3'h0;
	localparam logic [2:0] MANUAL_SEL_RST = 3'h0;
	localparam logic [2:0] RANK_MAX = 3'h4;
	// Time a locked input must be tracked before the history counts as valid
	localparam int unsigned HIST_TIME_NS = 10240;
	localparam int unsigned CLK_PERIOD_NS = 40;
	localparam int unsigned HIST_CYCLES = (HIST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {MODE_MANUAL, MODE_NONREVERT, MODE_REVERT, MODE_RESERVED} pcrsh_mode_t;
	typedef enum {ST_FREERUN, ST_LOCKED, ST_HOLDOVER} pcrsh_state_t;
	typedef struct packed {
		logic [3:0] offset;
		logic [3:0] loss;
	} pcrsh_alarms_t;
	typedef struct packed {
		logic locked;
		logic holdover;
		logic freerun;
		logic [1:0] input_num;
	} pcrsh_loop_t;
endpackage

// [dv/pcrsh_ref_src.sv]
// Behavioural model of the alarms of the four reference clock sources
module pcrsh_ref_src (
	input wire logic pclk,
	input wire logic [3:0] loss_req,
	input wire logic [3:0] offset_req,
	output pcrsh_pkg::pcrsh_alarms_t alarms
);
	timeunit 1ns;
	timeprecision 1ns;
	import pcrsh_pkg::*;
	// Alarms are qualified at the source, so they only move on a clock edge
	always_ff @(posedge pclk)
	begin
		alarms.loss <= loss_req;
		alarms.offset <= offset_req;
	end
endmodule

// [dv/pcrsh_chk.sv]
// Checker of bus handshake, loop status and applied settings
module pcrsh_chk #(
	parameter int unsigned HIST_LEN = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pcrsh_pkg::ADDR_W+1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire pcrsh_pkg::pcrsh_loop_t loop_status,
	input wire logic [9:0] phase_measure_threshold,
	input wire logic hitless_enable,
	input wire logic [5:0] exit_bandwidth_param [pcrsh_pkg::N_EXIT_BW]
);
	timeunit 1ns;
	timeprecision 1ns;
	import pcrsh_pkg::*;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic wr;
	logic nxt_ap;
	logic ap_ff;
	logic [35:0] bw;
	assign wr = psel && penable && pready && pwrite;
	assign nxt_ap = wr && pwdata[0] && (paddr[13:2] == IDX_BW_APPLY || paddr[13:2] == IDX_SOFT_RESET);
	always_comb
	begin
		for (int k = 0; k < N_EXIT_BW; k++)
			bw[6*k +: 6] = exit_bandwidth_param[k];
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ap_ff <= 1'b0;
		else
			ap_ff <= nxt_ap;
	end
	property p_ack; psel && penable && !pready |=> pready; endproperty
	property p_pulse; pready |=> !pready; endproperty
	property p_err; pslverr |-> pready; endproperty
	property p_state; $onehot({loop_status.locked, loop_status.holdover, loop_status.freerun}); endproperty
	property p_thr_lo; wr && paddr[13:2] == CFG_IDX[CFG_THR_LO] |=> phase_measure_threshold[7:0] == $past(pwdata[7:0]);
	endproperty
	property p_thr_hi; wr && paddr[13:2] == CFG_IDX[CFG_THR_HI] |=> phase_measure_threshold[9:8] == $past(pwdata[1:0]);
	endproperty
	property p_hsw; wr && paddr[13:2] == IDX_SEL_MODE |=> hitless_enable == $past(pwdata[2]); endproperty
	property p_bw; $changed(bw) |-> ap_ff || $past(ap_ff); endproperty
	a_ack: assert property (p_ack) else $error("no answer after access");
	a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
	a_err: assert property (p_err) else $error("error without ready");
	a_state: assert property (p_state) else $error("loop state not one-hot");
	a_thr_lo: assert property (p_thr_lo) else $error("threshold low byte wrong");
	a_thr_hi: assert property (p_thr_hi) else $error("threshold high bits wrong");
	a_hsw: assert property (p_hsw) else $error("hitless enable wrong");
	a_bw: assert property (p_bw) else $error("bandwidth moved without apply");
	c_apply: cover property (nxt_ap);
	c_hold: cover property (loop_status.holdover);
	c_err: cover property (pslverr);
endmodule

bind pcrsh_top pcrsh_chk #(.HIST_LEN(HIST_LEN)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
	.loop_status(loop_status), .phase_measure_threshold(phase_measure_threshold),
	.hitless_enable(hitless_enable), .exit_bandwidth_param(exit_bandwidth_param));

// [dv/testbench.sv]
// Self-checking bench for reference selection and holdover supervision
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import pcrsh_pkg::*;
	localparam int unsigned HL = 16;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [ADDR_W+1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic fast_lock_engaged = 0;
	logic [3:0] loss_req = '0;
	logic [3:0] offset_req = '0;
	pcrsh_alarms_t ref_alarms;
	pcrsh_loop_t loop_status;
	logic [9:0] phase_measure_threshold;
	logic hitless_enable;
	logic [5:0] exit_bandwidth_param [N_EXIT_BW];
	int n_fail = 0;
	int n_checks = 0;
	logic [7:0] rd;
	logic er;
	pcrsh_top #(.HIST_LEN(HL)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ref_alarms(ref_alarms), .fast_lock_engaged(fast_lock_engaged), .loop_status(loop_status),
		.phase_measure_threshold(phase_measure_threshold), .hitless_enable(hitless_enable),
		.exit_bandwidth_param(exit_bandwidth_param));
	pcrsh_ref_src src (.pclk(pclk), .loss_req(loss_req), .offset_req(offset_req), .alarms(ref_alarms));
	initial
	begin
		forever #20 pclk = ~pclk;
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Request is held until ready is seen at a rising edge
	task automatic apb(input logic w, input logic [ADDR_W-1:0] idx, input logic [7:0] d);
		int t;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= 32'(d);
		@(posedge pclk);
		penable <= 1'b1;
		t = 0;
		do
		begin
			@(posedge pclk);
			t++;
		end
		while (pready !== 1'b1 && t < 20);
		rd = prdata[7:0];
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		`CHK(t < 20, 1'b1)
	endtask
	task automatic st(input logic [2:0] m, input logic [1:0] n);
		int t;
		t = 0;
		// A locked target also waits for the input number, since the old lock may still show
		while ((loop_status[4:2] !== m || (m == 3'h4 && loop_status.input_num !== n)) && t < 12)
		begin
			@(posedge pclk);
			t++;
		end
		`CHK(loop_status[4:2], m)
		if (m == 3'h4)
			`CHK(loop_status.input_num, n)
	endtask
	task automatic t_regs();
		for (int k = 0; k < N_CFG; k++)
		begin
			apb(1'b0, CFG_IDX[k], 8'h00);
			`CHK(rd, CFG_RESET[k])
			if (k != CFG_HSW)
				apb(1'b1, CFG_IDX[k], 8'hFF);
			apb(1'b0, CFG_IDX[k], 8'h00);
			`CHK(rd, CFG_MASK[k] & (k == CFG_HSW ? CFG_RESET[k] : 8'hFF))
		end
		apb(1'b0, IDX_ALARM_MASK, 8'h00);
		`CHK(rd, ALARM_MASK_RST)
		apb(1'b0, 12'h000, 8'h00);
		`CHK(er, 1'b1)
		apb(1'b1, IDX_HIST_STATUS, 8'hFF);
		`CHK(er, 1'b0)
		`CHK(exit_bandwidth_param[0], 6'h00)
		$display("t_regs done");
	endtask
	task automatic t_manual();
		apb(1'b1, CFG_IDX[CFG_THR_LO], 8'hA5);
		apb(1'b1, CFG_IDX[CFG_THR_HI], 8'hFE);
		@(posedge pclk);
		`CHK(phase_measure_threshold, 10'h2A5)
		apb(1'b1, IDX_MANUAL_SEL, 8'h02);
		st(3'h4, 2'd2);
		repeat (3*HL) @(posedge pclk);
		apb(1'b0, IDX_HIST_STATUS, 8'h00);
		`CHK(rd[HIST_VALID_BIT], 1'b1)
		loss_req <= 4'h4;
		st(3'h2, 2'd0);
		repeat (3*HL) @(posedge pclk);
		apb(1'b0, IDX_HIST_STATUS, 8'h00);
		`CHK(rd[HIST_VALID_BIT], 1'b1)
		apb(1'b1, IDX_ALARM_MASK, 8'h04);
		st(3'h4, 2'd2);
		apb(1'b0, IDX_HIST_STATUS, 8'h00);
		`CHK(rd[HIST_VALID_BIT], 1'b0)
		offset_req <= 4'h4;
		st(3'h1, 2'd0);
		apb(1'b1, IDX_ALARM_MASK, 8'h44);
		st(3'h4, 2'd2);
		$display("t_manual done");
	endtask
	task automatic t_auto();
		apb(1'b1, IDX_RANK01, 8'h13);
		apb(1'b1, IDX_RANK23, 8'h20);
		apb(1'b1, IDX_SEL_MODE, 8'h06);
		st(3'h4, 2'd1);
		`CHK(hitless_enable, 1'b1)
		loss_req <= 4'h2;
		st(3'h4, 2'd3);
		loss_req <= 4'h0;
		st(3'h4, 2'd1);
		apb(1'b1, IDX_SEL_MODE, 8'h01);
		loss_req <= 4'h2;
		st(3'h4, 2'd3);
		`CHK(hitless_enable, 1'b0)
		loss_req <= 4'h0;
		repeat (3*HL) @(posedge pclk);
		st(3'h4, 2'd3);
		loss_req <= 4'hF;
		st(3'h2, 2'd0);
		apb(1'b0, IDX_ACTIVE, 8'h00);
		`CHK(rd, 8'h0B)
		$display("t_auto done");
	endtask
	task automatic t_bw();
		for (int k = 0; k < N_EXIT_BW; k++)
			apb(1'b1, CFG_IDX[CFG_EXIT_BW+k], 8'(k+1));
		apb(1'b1, IDX_SOFT_RESET, 8'h08);
		st(3'h1, 2'd0);
		`CHK(exit_bandwidth_param[5], 6'h00)
		apb(1'b0, IDX_HIST_STATUS, 8'h00);
		`CHK(rd[HIST_VALID_BIT], 1'b0)
		fast_lock_engaged <= 1'b1;
		apb(1'b0, IDX_HIST_STATUS, 8'h00);
		`CHK(rd[FAST_ACTIVE_BIT], 1'b1)
		apb(1'b1, IDX_BW_APPLY, 8'h01);
		repeat (2) @(posedge pclk);
		`CHK(exit_bandwidth_param[5], 6'h06)
		fast_lock_engaged <= 1'b0;
		apb(1'b1, CFG_IDX[CFG_EXIT_BW], 8'h2A);
		apb(1'b0, IDX_HIST_STATUS, 8'h00);
		`CHK(rd[FAST_ACTIVE_BIT], 1'b0)
		`CHK(exit_bandwidth_param[0], 6'h01)
		apb(1'b1, IDX_SOFT_RESET, 8'h01);
		repeat (2) @(posedge pclk);
		`CHK(exit_bandwidth_param[0], 6'h2A)
		$display("t_bw done");
	endtask
	initial
	begin
		repeat (4000) @(posedge pclk);
		n_fail++;
		$display("[ERR] %0t watchdog expired", $time);
		tally_and_finish();
	end
	initial
	begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_manual();
		t_auto();
		t_bw();
		tally_and_finish();
	end
endmodule
